// File: bench/core_external_interrupt_controller_tb.sv
// Self-checking testbench of the core external interrupt controller
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module core_external_interrupt_controller_tb;
    import intc_pkg::*;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [NUM_SRC:1] src_req;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic we = 1'b0;
    logic re = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic notify;
    logic wake;
    logic [31:0] d;
    int mismatches = 0;
    int num_checks = 0;

    always #20 sys_clk = ~sys_clk;

    irq_src_model irq_src_model_i (
        .sys_clk_i(sys_clk),
        .src_req_o(src_req)
    );

    core_ext_intc core_ext_intc_i (
        .sys_clk_i(sys_clk),
        .arst_n_i(arst_n),
        .src_req_i(src_req),
        .addr_i(addr),
        .wdata_i(wdata),
        .we_i(we),
        .re_i(re),
        .rdata_o(rdata),
        .notify_o(notify),
        .wake_o(wake)
    );

    function automatic logic [12:0] pa(input rgn_t r, input int k);
        pa = {r, k[7:0], 2'h0};
    endfunction

    task automatic wr(input logic [12:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        addr <= a;
        wdata <= v;
        we <= 1'b1;
        @(posedge sys_clk);
        we <= 1'b0;
    endtask

    task automatic rd(input logic [12:0] a, output logic [31:0] v);
        @(posedge sys_clk);
        addr <= a;
        re <= 1'b1;
        @(posedge sys_clk);
        re <= 1'b0;
        @(negedge sys_clk);
        v = rdata;
    endtask

    // Write directly followed by a read, no idle cycle between strobes
    task automatic wr_rd(input logic [12:0] aw, input logic [31:0] v, input logic [12:0] ar,
        output logic [31:0] r);
        @(posedge sys_clk);
        addr <= aw;
        wdata <= v;
        we <= 1'b1;
        @(posedge sys_clk);
        addr <= ar;
        we <= 1'b0;
        re <= 1'b1;
        @(posedge sys_clk);
        re <= 1'b0;
        @(negedge sys_clk);
        r = rdata;
    endtask

    // Two full evaluation sweeps plus output registers
    task automatic settle();
        repeat (530) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
        begin
            $display("All tests passed");
        end
        else
        begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic test_reset();
        @(negedge sys_clk);
        `CHK("notify", 1'b0, notify)
        `CHK("wake", 1'b0, wake)
        rd(OFS_THRESH, d);
        `CHK("thresh", 32'h0000_0000, d)
        rd(pa(RGN_EN, 0), d);
        `CHK("index zero", 32'h0000_0000, d)
    endtask

    task automatic test_tie();
        wr(pa(RGN_PRI, 10), 32'h5);
        wr(pa(RGN_PRI, 20), 32'h5);
        wr(pa(RGN_EN, 10), 32'h1);
        wr(pa(RGN_EN, 20), 32'h1);
        irq_src_model_i.set_level(20, 1'b1);
        irq_src_model_i.set_level(10, 1'b1);
        settle();
        rd(OFS_STATUS, d);
        `CHK("status tie", 32'h0000_550A, d)
        `CHK("notify tie", 1'b1, notify)
    endtask

    task automatic test_thresh();
        wr_rd(OFS_THRESH, 32'h5, OFS_THRESH, d);
        `CHK("thresh back", 32'h5, d)
        settle();
        `CHK("notify thresh eq", 1'b0, notify)
        wr(OFS_THRESH, 32'h4);
        settle();
        `CHK("notify thresh below", 1'b1, notify)
        wr(OFS_THRESH, 32'h0);
        wr(OFS_CURPRI, 32'h5);
        settle();
        `CHK("notify nested", 1'b0, notify)
        wr(OFS_CURPRI, 32'h0);
        settle();
        `CHK("notify unnested", 1'b1, notify)
    endtask

    task automatic test_disabled();
        wr(pa(RGN_PRI, 9), 32'h9);
        irq_src_model_i.set_level(9, 1'b1);
        settle();
        rd(pa(RGN_PEND, 9), d);
        `CHK("simple gateway", 32'h1, d)
        rd(OFS_STATUS, d);
        `CHK("disabled id", 8'h0A, d[7:0])
    endtask

    task automatic test_edge();
        wr(pa(RGN_GWCTL, 1), 32'h2);
        wr(pa(RGN_PRI, 1), 32'h7);
        wr(pa(RGN_EN, 1), 32'h1);
        irq_src_model_i.pulse(1, 3);
        settle();
        rd(pa(RGN_PEND, 1), d);
        `CHK("latched", 32'h1, d)
        rd(OFS_STATUS, d);
        `CHK("latched id", 8'h01, d[7:0])
        wr(pa(RGN_GWCLR, 1), 32'h0);
        rd(pa(RGN_PEND, 1), d);
        `CHK("cleared", 32'h0, d)
        irq_src_model_i.set_level(1, 1'b1);
        repeat (8) @(posedge sys_clk);
        wr(pa(RGN_GWCLR, 1), 32'h0);
        rd(pa(RGN_PEND, 1), d);
        `CHK("reset by level", 32'h1, d)
        irq_src_model_i.set_level(1, 1'b0);
        repeat (8) @(posedge sys_clk);
        wr(pa(RGN_GWCLR, 1), 32'h0);
        rd(pa(RGN_PEND, 1), d);
        `CHK("idle cleared", 32'h0, d)
    endtask

    task automatic test_polarity();
        irq_src_model_i.set_level(4, 1'b1);
        wr(pa(RGN_GWCTL, 4), 32'h1);
        repeat (8) @(posedge sys_clk);
        rd(pa(RGN_PEND, 4), d);
        `CHK("low idle", 32'h0, d)
        irq_src_model_i.set_level(4, 1'b0);
        repeat (6) @(posedge sys_clk);
        rd(pa(RGN_PEND, 4), d);
        `CHK("low active", 32'h1, d)
        irq_src_model_i.set_level(4, 1'b1);
    endtask

    task automatic test_wake();
        wr(pa(RGN_PRI, 40), 32'hF);
        wr(pa(RGN_EN, 40), 32'h1);
        irq_src_model_i.set_level(40, 1'b1);
        settle();
        `CHK("wake top", 1'b1, wake)
        rd(OFS_STATUS, d);
        `CHK("status top", 32'h0000_7F28, d)
        wr(OFS_VTBASE, 32'hABCD_E400);
        wr_rd(OFS_CLAIM, 32'h0, OFS_HPTR, d);
        `CHK("handler ptr", 32'hABCD_E4A0, d)
        rd(OFS_CLAIM_PRI, d);
        `CHK("claim pri", 32'hF, d)
        irq_src_model_i.set_level(40, 1'b0);
        settle();
        `CHK("wake gone", 1'b0, wake)
    endtask

    task automatic test_reverse();
        wr(OFS_CFG, 32'h1);
        rd(pa(RGN_PRI, 10), d);
        `CHK("rev pri read", 32'hA, d)
        rd(OFS_THRESH, d);
        `CHK("rev thresh read", 32'hF, d)
        wr(pa(RGN_PRI, 10), 32'h0);
        settle();
        `CHK("rev wake", 1'b1, wake)
        `CHK("rev notify", 1'b1, notify)
        rd(OFS_STATUS, d);
        `CHK("rev status pri", 4'h0, d[11:8])
        `CHK("rev status id", 8'h0A, d[7:0])
        wr_rd(OFS_THRESH, 32'hF, OFS_THRESH, d);
        `CHK("rev thresh back", 32'hF, d)
    endtask

    initial
    begin
        #(40 * 20000);
        mismatches++;
        complete_run();
    end

    initial
    begin
        repeat (5) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        test_reset();
        test_tie();
        test_thresh();
        test_disabled();
        test_edge();
        test_polarity();
        test_wake();
        test_reverse();
        complete_run();
    end
endmodule

// File: bench/irq_src_model.sv
// Behavioural model of the interrupt sources feeding the controller
`timescale 1ns/1ps
module irq_src_model (
    input wire logic sys_clk_i,
    output logic [intc_pkg::NUM_SRC:1] src_req_o
);
    import intc_pkg::*;
    logic [NUM_SRC:1] req_q = '0;
    assign src_req_o = req_q;
    // Change one source level and hold it
    task automatic set_level(input int k, input logic v);
        @(posedge sys_clk_i);
        req_q[k] <= v;
        repeat (2) @(posedge sys_clk_i);
    endtask
    // Active pulse, never shorter than two clocks
    task automatic pulse(input int k, input int len);
        @(posedge sys_clk_i);
        req_q[k] <= 1'b1;
        repeat ((len < 2) ? 2 : len) @(posedge sys_clk_i);
        req_q[k] <= 1'b0;
    endtask
endmodule

// File: verilog/core_ext_intc.sv
// Core external interrupt controller: gateways, evaluation, registers
// Notes on behaviour
// - Up to 255 sources, ID 1 highest, each with its own enable.
// - Each source has a programmable priority, 1 lowest to 15 highest.
// - A reverse order bit makes software see 14 lowest to 0 highest.
// - A threshold masks notify for every request whose priority is not above it; wake ignores it.
// - Wake-up is raised when the chosen priority equals the top level.
// - Every source passes a gateway giving an active-high level request.
// - At most one outstanding request per source is tracked.
// - Simple gateways only synchronise and keep no state.
// - Configurable gateways select edge or level and polarity.
// - In edge mode a pending latch holds the request as a level.
// - The pending latch stays set until software clears it.
// - No edge detect: an active input keeps setting the latch.
// - Highest priority among pending and enabled wins, ties to lowest ID.
// - Notify only when priority exceeds threshold and running priority.
// - The chosen source ID is readable in a status register.
// - Pipeline stages delay ID, priority and valid flag equally; notify and wake flags one cycle more.
// - Evaluation runs in normal order; registers invert in reverse mode.
// - Priorities written and read are inverted in reverse mode.
// - Wake bit set for top pending priority 15, or 0 when reversed.
// - Handler pointer is table base, claimed ID, then two zero bits.
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module core_ext_intc (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic [intc_pkg::NUM_SRC:1] src_req_i,
    input wire logic [intc_pkg::ADDR_W-1:0] addr_i,
    input wire logic [intc_pkg::DATA_W-1:0] wdata_i,
    input wire logic we_i,
    input wire logic re_i,
    output logic [intc_pkg::DATA_W-1:0] rdata_o,
    output logic notify_o,
    output logic wake_o
);
    import intc_pkg::*;

    localparam int LVL_PROBE = CFG_GW_NUM + 1;

    function automatic pri_t order_map(input pri_t p, input logic rev);
        order_map = p ^ {PRI_W{rev}};
    endfunction

    function automatic logic idx_ok(input id_t i);
        idx_ok = (i != ID_NONE);
    endfunction

    prio_mem_if mif ();

    prio_mem prio_mem_i (
        .sys_clk_i(sys_clk_i),
        .mif(mif)
    );

    rgn_t rgn;
    id_t idx;
    logic misc_wr;
    logic gw_wr;
    logic gw_clr;
    assign rgn = addr_i[RGN_MSB:RGN_LSB];
    assign idx = addr_i[IDX_MSB:IDX_LSB];
    assign misc_wr = we_i && rgn == RGN_MISC;
    assign gw_wr = we_i && rgn == RGN_GWCTL && idx_ok(idx) && idx <= CFG_ID_LAST;
    assign gw_clr = we_i && rgn == RGN_GWCLR && idx_ok(idx) && idx <= CFG_ID_LAST;

    logic rev_q;
    pri_t thresh_q;
    pri_t curpri_q;
    logic [VTBASE_W-1:0] vtbase_q;

    // Control registers, priorities kept in normal order inside
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rev_q <= 1'b0;
            thresh_q <= PRI_NONE;
            curpri_q <= PRI_NONE;
            vtbase_q <= '0;
        end
        else if (misc_wr)
        begin
            case (addr_i)
                OFS_CFG: rev_q <= wdata_i[CFG_REV_BIT];
                OFS_THRESH: thresh_q <= order_map(wdata_i[PRI_W-1:0], rev_q);
                OFS_CURPRI: curpri_q <= order_map(wdata_i[PRI_W-1:0], rev_q);
                OFS_VTBASE: vtbase_q <= wdata_i[DATA_W-1:DATA_W-VTBASE_W];
                default: ;
            endcase
        end
    end

    // Priority writes and reads through the memory, inverted when reversed
    assign mif.we = we_i && rgn == RGN_PRI && idx_ok(idx);
    assign mif.waddr = idx;
    assign mif.wdata = order_map(wdata_i[PRI_W-1:0], rev_q);
    assign mif.raddr_b = idx;

    logic [NUM_SRC:1] en_q;

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            en_q <= '0;
        end
        else if (we_i && rgn == RGN_EN && idx_ok(idx))
        begin
            en_q[idx] <= wdata_i[EN_BIT];
        end
    end

    // Three-stage synchronisers, a change counts once stages two and three agree
    logic [NUM_SRC:1] s1_q;
    logic [NUM_SRC:1] s2_q;
    logic [NUM_SRC:1] s3_q;
    logic [NUM_SRC:1] filt_q;

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            filt_q <= '0;
        end
        else
        begin
            s1_q <= src_req_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            filt_q <= (s2_q & s3_q) | (filt_q & (s2_q ^ s3_q));
        end
    end

    // Configurable gateways on the low source numbers
    logic [CFG_GW_NUM:1] pol_q;
    logic [CFG_GW_NUM:1] edge_q;
    logic [CFG_GW_NUM:1] pending_latch_q;
    logic [CFG_GW_NUM:1] gw_act;
    logic [NUM_SRC:1] req;

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            pol_q <= '0;
            edge_q <= '0;
        end
        else if (gw_wr)
        begin
            pol_q[idx] <= wdata_i[GW_POL_BIT];
            edge_q[idx] <= wdata_i[GW_EDGE_BIT];
        end
    end

    assign gw_act = filt_q[CFG_GW_NUM:1] ^ pol_q;

    // In edge mode an active input sets the latch, and a set beats a same-cycle clear
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            pending_latch_q <= '0;
        end
        else
        begin
            for (int k = 1; k <= CFG_GW_NUM; k++)
            begin
                if (edge_q[k] && gw_act[k])
                begin
                    pending_latch_q[k] <= 1'b1;
                end
                else if (gw_clr && idx == id_t'(k))
                begin
                    pending_latch_q[k] <= 1'b0;
                end
            end
        end
    end

    // One request bit per source
    assign req[CFG_GW_NUM:1] = (edge_q & pending_latch_q) | (~edge_q & gw_act);
    assign req[NUM_SRC:LVL_PROBE] = filt_q[NUM_SRC:LVL_PROBE];

    // Sequential evaluation, one source per cycle
    id_t scan_idx_q;
    id_t st_id_q;
    logic st_ok_q;
    logic best_v_q;
    pri_t best_pri_q;
    id_t best_id_q;
    logic max_v_q;
    pri_t max_pri_q;
    id_t max_id_q;
    logic take;
    logic nb_v;
    pri_t nb_pri;
    id_t nb_id;

    assign mif.raddr_a = scan_idx_q;

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            scan_idx_q <= ID_FIRST;
            st_id_q <= ID_NONE;
            st_ok_q <= 1'b0;
        end
        else
        begin
            scan_idx_q <= (scan_idx_q == ID_LAST) ? ID_FIRST : scan_idx_q + ID_FIRST;
            st_id_q <= scan_idx_q;
            st_ok_q <= req[scan_idx_q] & en_q[scan_idx_q];
        end
    end

    // Ascending scan: only a strictly higher priority replaces the best
    assign take = st_ok_q && (!best_v_q || mif.rdata_a > best_pri_q);
    assign nb_v = best_v_q || take;
    assign nb_pri = take ? mif.rdata_a : best_pri_q;
    assign nb_id = take ? st_id_q : best_id_q;

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            best_v_q <= 1'b0;
            best_pri_q <= PRI_NONE;
            best_id_q <= ID_NONE;
            max_v_q <= 1'b0;
            max_pri_q <= PRI_NONE;
            max_id_q <= ID_NONE;
        end
        else if (st_id_q == ID_LAST)
        begin
            max_v_q <= nb_v;
            max_pri_q <= nb_pri;
            max_id_q <= nb_id;
            best_v_q <= 1'b0;
            best_pri_q <= PRI_NONE;
            best_id_q <= ID_NONE;
        end
        else if (st_id_q != ID_NONE)
        begin
            best_v_q <= nb_v;
            best_pri_q <= nb_pri;
            best_id_q <= nb_id;
        end
    end

    logic notify_q;
    logic wake_notify_bit_q;
    id_t claim_id_q;
    pri_t claim_pri_q;

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            notify_q <= 1'b0;
            wake_notify_bit_q <= 1'b0;
        end
        else
        begin
            notify_q <= max_v_q && max_pri_q > thresh_q && max_pri_q > curpri_q;
            wake_notify_bit_q <= max_v_q && max_pri_q == PRI_MAX;
        end
    end

    // Claim capture ignores thresholds
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            claim_id_q <= ID_NONE;
            claim_pri_q <= PRI_NONE;
        end
        else if (misc_wr && addr_i == OFS_CLAIM)
        begin
            claim_id_q <= max_id_q;
            claim_pri_q <= max_pri_q;
        end
    end

    assign notify_o = notify_q;
    assign wake_o = wake_notify_bit_q;

    // Read path, data in the cycle after the strobe
    logic [DATA_W-1:0] rd_data_q;
    logic rd_mem_q;

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rd_data_q <= '0;
            rd_mem_q <= 1'b0;
        end
        else
        begin
            rd_mem_q <= re_i && rgn == RGN_PRI && idx_ok(idx);
            rd_data_q <= '0;
            if (re_i)
            begin
                case (rgn)
                    RGN_MISC:
                    begin
                        case (addr_i)
                            OFS_CFG: rd_data_q <= DATA_W'(rev_q);
                            OFS_THRESH: rd_data_q <= DATA_W'(order_map(thresh_q, rev_q));
                            OFS_CURPRI: rd_data_q <= DATA_W'(order_map(curpri_q, rev_q));
                            OFS_VTBASE: rd_data_q <= {vtbase_q, ID_NONE, HPTR_PAD};
                            OFS_HPTR: rd_data_q <= {vtbase_q, claim_id_q, HPTR_PAD};
                            OFS_CLAIM_PRI: rd_data_q <= DATA_W'(order_map(claim_pri_q, rev_q));
                            OFS_STATUS: rd_data_q <= DATA_W'({max_v_q, wake_notify_bit_q, notify_q,
                                order_map(max_pri_q, rev_q), max_id_q});
                            default: ;
                        endcase
                    end
                    RGN_EN:
                    begin
                        if (idx_ok(idx))
                        begin
                            rd_data_q[EN_BIT] <= en_q[idx];
                        end
                    end
                    RGN_GWCTL:
                    begin
                        if (idx_ok(idx) && idx <= CFG_ID_LAST)
                        begin
                            rd_data_q[GW_POL_BIT] <= pol_q[idx];
                            rd_data_q[GW_EDGE_BIT] <= edge_q[idx];
                        end
                    end
                    RGN_PEND:
                    begin
                        if (idx_ok(idx))
                        begin
                            rd_data_q[PEND_BIT] <= req[idx];
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    assign rdata_o = rd_mem_q ? DATA_W'(order_map(mif.rdata_b, rev_q)) : rd_data_q;

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!arst_n_i);

    sequence s_claim_then_read;
        misc_wr && addr_i == OFS_CLAIM ##1 re_i && rgn == RGN_MISC && addr_i == OFS_HPTR;
    endsequence

    sequence s_thresh_wr_rd;
        misc_wr && addr_i == OFS_THRESH ##1 re_i && rgn == RGN_MISC && addr_i == OFS_THRESH;
    endsequence

    sequence s_src_steady;
        $stable(src_req_i[LVL_PROBE]) [*4];
    endsequence

    property p_hptr;
        s_claim_then_read |=> rdata_o == {vtbase_q, $past(max_id_q, 2), HPTR_PAD};
    endproperty
    a_hptr: assert property (p_hptr) else $error("handler pointer wrong");

    property p_roundtrip;
        s_thresh_wr_rd |=> rdata_o[PRI_W-1:0] == $past(wdata_i[PRI_W-1:0], 2)
            && thresh_q == ($past(wdata_i[PRI_W-1:0], 2) ^ {PRI_W{rev_q}});
    endproperty
    a_roundtrip: assert property (p_roundtrip) else $error("threshold mapping wrong");

    property p_sync;
        s_src_steady |-> req[LVL_PROBE] == src_req_i[LVL_PROBE];
    endproperty
    a_sync: assert property (p_sync) else $error("gateway not following input");

    property p_notify;
        notify_o |-> $past(max_v_q) && $past(max_pri_q) > $past(thresh_q)
            && $past(max_pri_q) > $past(curpri_q);
    endproperty
    a_notify: assert property (p_notify) else $error("notify without cause");

    property p_thresh_block;
        max_v_q && max_pri_q <= thresh_q |=> !notify_o;
    endproperty
    a_thresh_block: assert property (p_thresh_block) else $error("threshold ignored");

    property p_wake;
        max_v_q && max_pri_q == PRI_MAX |=> wake_o;
    endproperty
    a_wake: assert property (p_wake) else $error("wake missing");

    property p_tie;
        st_ok_q && best_v_q && st_id_q != ID_LAST && mif.rdata_a == best_pri_q
            |=> best_id_q == $past(best_id_q);
    endproperty
    a_tie: assert property (p_tie) else $error("tie not to lowest id");

    property p_skip;
        !st_ok_q && st_id_q != ID_LAST && st_id_q != ID_NONE |=> $stable(best_id_q);
    endproperty
    a_skip: assert property (p_skip) else $error("inactive source chosen");

    property p_latch_hold;
        edge_q[1] && pending_latch_q[1] && !(gw_clr && idx == ID_FIRST) |=> pending_latch_q[1];
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch dropped");
endmodule

// File: verilog/intc_pkg.sv
// Constants and types of the core interrupt controller
package intc_pkg;
    localparam int NUM_SRC = 255;
    localparam int CFG_GW_NUM = 8;
    localparam int ID_W = 8;
    localparam int PRI_W = 4;
    localparam int ADDR_W = 13;
    localparam int DATA_W = 32;
    localparam int VTBASE_W = 22;
    localparam int RGN_LSB = 10;
    localparam int RGN_MSB = 12;
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 9;
    localparam int CFG_REV_BIT = 0;
    localparam int GW_POL_BIT = 0;
    localparam int GW_EDGE_BIT = 1;
    localparam int EN_BIT = 0;
    localparam int PEND_BIT = 0;
    typedef logic [ID_W-1:0] id_t;
    typedef logic [PRI_W-1:0] pri_t;
    typedef logic [2:0] rgn_t;
    localparam pri_t PRI_NONE = 4'h0;
    localparam pri_t PRI_MAX = 4'hF;
    localparam id_t ID_NONE = 8'h00;
    localparam id_t ID_FIRST = 8'h01;
    localparam id_t ID_LAST = 8'hFF;
    localparam id_t CFG_ID_LAST = 8'h08;
    localparam logic [1:0] HPTR_PAD = 2'h0;
    localparam rgn_t RGN_MISC = 3'h0;
    localparam rgn_t RGN_PRI = 3'h1;
    localparam rgn_t RGN_EN = 3'h2;
    localparam rgn_t RGN_GWCTL = 3'h3;
    localparam rgn_t RGN_GWCLR = 3'h4;
    localparam rgn_t RGN_PEND = 3'h5;
    localparam logic [ADDR_W-1:0] OFS_CFG = 13'h000;
    localparam logic [ADDR_W-1:0] OFS_THRESH = 13'h004;
    localparam logic [ADDR_W-1:0] OFS_CURPRI = 13'h008;
    localparam logic [ADDR_W-1:0] OFS_VTBASE = 13'h00C;
    localparam logic [ADDR_W-1:0] OFS_CLAIM = 13'h010;
    localparam logic [ADDR_W-1:0] OFS_HPTR = 13'h014;
    localparam logic [ADDR_W-1:0] OFS_CLAIM_PRI = 13'h018;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 13'h01C;
endpackage

// File: verilog/prio_mem.sv
// Per-source priority store, one write port, two registered read ports
`timescale 1ns/1ps
module prio_mem (
    input wire logic sys_clk_i,
    prio_mem_if.mem mif
);
    import intc_pkg::*;

    pri_t store [0:NUM_SRC];

    always_ff @(posedge sys_clk_i)
    begin
        if (mif.we)
        begin
            store[mif.waddr] <= mif.wdata;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        mif.rdata_a <= store[mif.raddr_a];
        mif.rdata_b <= store[mif.raddr_b];
    end
endmodule

// File: verilog/prio_mem_if.sv
// Port bundle between the controller and its priority memory
`timescale 1ns/1ps
interface prio_mem_if;
    import intc_pkg::*;
    logic we;
    id_t waddr;
    pri_t wdata;
    id_t raddr_a;
    pri_t rdata_a;
    id_t raddr_b;
    pri_t rdata_b;
    modport ctrl (output we, waddr, wdata, raddr_a, raddr_b, input rdata_a, rdata_b);
    modport mem (input we, waddr, wdata, raddr_a, raddr_b, output rdata_a, rdata_b);
endinterface
